/* pkg/clkgen_pkg.sv */
// Constants for the shift and video clock generator
package clkgen_pkg;
    // ----------------------------------------------------------------
    // Register map (word index, byte address is four times index)
    // ----------------------------------------------------------------
    localparam int          ADDR_W         = 2;
    localparam logic [1:0]  IDX_OCS        = 2'h0;    // output_clock_select
    localparam logic [1:0]  IDX_CTRL       = 2'h1;    // control
    localparam logic [1:0]  IDX_STATUS     = 2'h2;    // status, read only
    localparam logic [7:0]  OCS_RESET      = 8'h30;   // Video held high, shift 1:1
    localparam logic [7:0]  OCS_WMASK      = 8'h3f;   // Bits 7:6 read zero
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int          OCS_VID_LSB    = 3;
    localparam int          OCS_SHF_LSB    = 0;
    localparam int          SEL_W          = 3;
    localparam int          CTRL_ASSIST    = 0;       // Split transfer assist enable
    localparam int          ST_ASSIST      = 0;
    localparam int          ST_ARMED       = 1;
    localparam int          ST_BLANK       = 2;
    localparam int          ST_SHIFT       = 3;
    localparam int          ST_VIDEO       = 4;
    // ----------------------------------------------------------------
    // Shared counter: bit 0 is the dot phase, bit k divides by 2^(k+1)
    // ----------------------------------------------------------------
    localparam int          CNT_W          = 6;
    localparam logic [CNT_W-1:0] CNT_ZERO  = 6'h00;
    localparam logic [CNT_W-1:0] CNT_ONE   = 6'h01;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int          CLK_PERIOD_NS  = 100;
    localparam int          SPLIT_PW_NS    = 15;
    localparam int          SPLIT_PW_RAW   = (SPLIT_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          SPLIT_PW_CYC   = (SPLIT_PW_RAW < 1) ? 1 : SPLIT_PW_RAW;
    localparam int          TMR_W          = 4;
    localparam logic [TMR_W-1:0] TMR_ZERO  = 4'h0;
    localparam logic [TMR_W-1:0] TMR_ONE   = 4'h1;
    localparam logic [TMR_W-1:0] SPLIT_PW_T = TMR_W'(SPLIT_PW_CYC);
endpackage

/* core/shift_video_clock_generator.sv */
// Shift, video and latch clock generator with Avalon-MM register slave
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module shift_video_clock_generator
    import clkgen_pkg::*;
#(
    parameter int                PIX_W       = 32,
    parameter logic [TMR_W-1:0]  SPLIT_DELAY = 4'h2
) (
    input  wire logic               CORE_CLK_I,          // Core clock, two per dot
    input  wire logic               RST_N_I,             // Async reset, active low
    input  wire logic [ADDR_W-1:0]  AVS_ADDRESS_I,       // Word address
    input  wire logic               AVS_READ_I,          // Read request
    input  wire logic               AVS_WRITE_I,         // Write request
    input  wire logic [31:0]        AVS_WRITEDATA_I,     // Write data
    output logic [31:0]             AVS_READDATA_O,      // Read data
    output logic                    AVS_WAITREQUEST_O,   // Stall request
    input  wire logic               BLANK_N_I,           // Blanking pin, active low
    input  wire logic               SPLIT_FLAG_I,        // split_flag_input pin
    input  wire logic [PIX_W-1:0]   PIXEL_I,             // Pixel port
    output logic                    SHIFT_CLK_O,         // Gated shift clock
    output logic                    VIDEO_CLK_O,         // video_clock
    output logic                    LOAD_CLK_O,          // Latch clock, never blanked
    output logic [PIX_W-1:0]        PIXEL_O,             // Latched pixel group
    output logic                    BLANK_N_O,           // Aligned blanking, active low
    output logic                    FIRST_GROUP_O        // First group latched pulse
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0]        ocs;
        logic              assist;
        logic [CNT_W-1:0]  cnt;
        logic              blank_m;     // Synchroniser first stages
        logic              blank_s;
        logic              split_m;
        logic              split_s;
        logic              split_d;
        logic [PIX_W-1:0]  pix_m;
        logic [PIX_W-1:0]  pix_s;
        logic              vid;
        logic              raw;
        logic              sclk;
        logic              blank_smp;   // 1 while sampled blanking active
        logic              split_seen;
        logic              armed;
        logic              skip;
        logic              first;
        logic [PIX_W-1:0]  pix_out;
        logic              blank_out;
        logic              busy;
        logic              firing;
        logic [TMR_W-1:0]  tmr;
        logic              wait_req;
        logic [31:0]       rdata;
    } state_t;

    state_t st_reg;
    state_t st_next;

    // Clock select decode, used for both outputs
    function automatic logic sel_off(input logic [SEL_W-1:0] sel);
        sel_off = sel[2] & sel[1];
    endfunction

    // Tap of the shared counter for a code; high during first half period
    function automatic logic sel_tap(input logic [SEL_W-1:0] sel,
                                     input logic [CNT_W-1:0] cnt);
        sel_tap = ~cnt[sel];
    endfunction

    logic [SEL_W-1:0] vid_sel;
    logic [SEL_W-1:0] shf_sel;
    logic             cnt_clear;
    logic             split_rise;
    logic             bus_take;
    logic             raw_rise;
    logic             sclk_rise;

    assign vid_sel    = st_reg.ocs[OCS_VID_LSB +: SEL_W];
    assign shf_sel    = st_reg.ocs[OCS_SHF_LSB +: SEL_W];
    assign cnt_clear  = sel_off(vid_sel) & sel_off(shf_sel);
    assign split_rise = st_reg.split_s & ~st_reg.split_d;
    assign bus_take   = (AVS_READ_I | AVS_WRITE_I) & ~st_reg.wait_req;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next   = st_reg;
        raw_rise  = 1'b0;
        sclk_rise = 1'b0;

        // Pin synchronisers
        st_next.blank_m = ~BLANK_N_I;
        st_next.blank_s = st_reg.blank_m;
        st_next.split_m = SPLIT_FLAG_I;
        st_next.split_s = st_reg.split_m;
        st_next.split_d = st_reg.split_s;
        st_next.pix_m   = PIXEL_I;
        st_next.pix_s   = st_reg.pix_m;

        if (cnt_clear) begin
            st_next.cnt = CNT_ZERO;
        end else begin
            st_next.cnt = st_reg.cnt + CNT_ONE;
        end

        st_next.vid = sel_off(vid_sel) ? 1'b1 : sel_tap(vid_sel, st_next.cnt);

        // sample blanking on video clock falling edge
        if (st_reg.vid & ~st_next.vid) begin
            st_next.blank_smp = st_reg.blank_s;
        end

        // ungated shift clock doubles as latch clock
        st_next.raw = sel_off(shf_sel) ? 1'b0 : sel_tap(shf_sel, st_next.cnt);
        raw_rise    = st_next.raw & ~st_reg.raw;

        // split assist: delay then fixed-width pulse
        if (st_reg.busy) begin
            if (st_reg.tmr != TMR_ZERO) begin
                st_next.tmr = st_reg.tmr - TMR_ONE;
            end else if (!st_reg.firing) begin
                st_next.firing = 1'b1;
                st_next.tmr    = SPLIT_PW_T - TMR_ONE;
            end else begin
                st_next.firing = 1'b0;
                st_next.busy   = 1'b0;
            end
        end else if (split_rise && st_reg.assist && !sel_off(shf_sel)) begin
            st_next.busy = 1'b1;
            st_next.tmr  = SPLIT_DELAY;
        end

        // gate: start on raw rise or split pulse, finish any high phase
        if (sel_off(shf_sel)) begin
            st_next.sclk = 1'b0;
        end else begin
            st_next.sclk = st_next.firing |
                           (st_next.raw & (st_reg.sclk | (raw_rise & ~st_next.blank_smp)));
        end
        sclk_rise = st_next.sclk & ~st_reg.sclk;

        // a pulse during blanking counts as the split pulse
        if (sclk_rise && st_reg.blank_smp) begin
            st_next.split_seen = 1'b1;
        end

        // arm first group search when blanking ends
        st_next.first = 1'b0;
        if (st_reg.blank_smp && !st_next.blank_smp) begin
            st_next.armed      = 1'b1;
            st_next.skip       = ~st_next.split_seen;
            st_next.split_seen = 1'b0;
        end else if (sclk_rise && st_reg.armed && !st_next.blank_smp) begin
            if (st_reg.skip) begin
                st_next.skip = 1'b0;
            end else begin
                st_next.armed = 1'b0;
                st_next.first = 1'b1;
            end
        end

        // latch pixels and blanking together on latch clock rise
        if (raw_rise) begin
            st_next.pix_out   = st_reg.pix_s;
            st_next.blank_out = st_reg.blank_smp;
        end

        // Avalon-MM slave, one wait cycle per access
        st_next.wait_req = ~((AVS_READ_I | AVS_WRITE_I) & st_reg.wait_req);
        if (AVS_READ_I && st_reg.wait_req) begin
            case (AVS_ADDRESS_I)
                IDX_OCS: begin
                    st_next.rdata = {24'h000000, st_reg.ocs};
                end
                IDX_CTRL: begin
                    st_next.rdata = 32'h00000000;
                    st_next.rdata[CTRL_ASSIST] = st_reg.assist;
                end
                IDX_STATUS: begin
                    st_next.rdata = 32'h00000000;
                    st_next.rdata[ST_ASSIST] = st_reg.busy;
                    st_next.rdata[ST_ARMED]  = st_reg.armed;
                    st_next.rdata[ST_BLANK]  = st_reg.blank_smp;
                    st_next.rdata[ST_SHIFT]  = st_reg.sclk;
                    st_next.rdata[ST_VIDEO]  = st_reg.vid;
                end
                default: begin
                    st_next.rdata = 32'h00000000;
                end
            endcase
        end
        if (AVS_WRITE_I && bus_take) begin
            case (AVS_ADDRESS_I)
                IDX_OCS: begin
                    st_next.ocs = AVS_WRITEDATA_I[7:0] & OCS_WMASK;
                end
                IDX_CTRL: begin
                    st_next.assist = AVS_WRITEDATA_I[CTRL_ASSIST];
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // reset values
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st_reg          <= '0;
            st_reg.ocs      <= OCS_RESET;
            st_reg.vid      <= 1'b1;
            st_reg.wait_req <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flops, BLANK_N_O through an inverter
    assign SHIFT_CLK_O       = st_reg.sclk;
    assign VIDEO_CLK_O       = st_reg.vid;
    assign LOAD_CLK_O        = st_reg.raw;
    assign PIXEL_O           = st_reg.pix_out;
    assign BLANK_N_O         = ~st_reg.blank_out;
    assign FIRST_GROUP_O     = st_reg.first;
    assign AVS_READDATA_O    = st_reg.rdata;
    assign AVS_WAITREQUEST_O = st_reg.wait_req;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    localparam int SPL_LO = 3;
    localparam int SPL_HI = 24;

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);

    a_video_off_high: assert property (
        sel_off(vid_sel) && $stable(st_reg.ocs) |=> VIDEO_CLK_O)
        else $error("video clock not held high when disabled");
    a_shift_off_low: assert property (
        sel_off(shf_sel) |=> !SHIFT_CLK_O)
        else $error("shift clock not low when switched off");
    a_counter_clear: assert property (
        cnt_clear |=> st_reg.cnt == CNT_ZERO)
        else $error("shared counter not cleared");
    a_blank_sampled: assert property (
        $fell(st_reg.vid) |-> st_reg.blank_smp == $past(st_reg.blank_s))
        else $error("blanking not sampled on video clock fall");
    a_blank_holds_low: assert property (
        st_reg.blank_smp && st_next.blank_smp && !SHIFT_CLK_O && !st_reg.busy && !split_rise
        |=> !SHIFT_CLK_O)
        else $error("shift clock rose during blanking");
    a_high_phase_done: assert property (
        SHIFT_CLK_O && st_reg.raw && !sel_off(shf_sel) && $stable(st_reg.ocs)
        && !cnt_clear |=> SHIFT_CLK_O == st_reg.raw)
        else $error("shift high phase cut short");
    a_latch_capture: assert property (
        $rose(st_reg.raw) |-> PIXEL_O == $past(st_reg.pix_s)
                              && BLANK_N_O == !$past(st_reg.blank_smp))
        else $error("latch clock did not capture pixels and blanking");
    a_split_pulse: assert property (
        split_rise && st_reg.assist && !st_reg.busy && !sel_off(shf_sel)
        && $stable(st_reg.ocs) |-> ##[SPL_LO:SPL_HI] SHIFT_CLK_O)
        else $error("split assist pulse missing");
    a_bus_answer: assert property (
        (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("waitrequest not released after one cycle");

    c_first_normal: cover property (FIRST_GROUP_O && !$past(st_reg.split_seen, 2));
    c_first_split: cover property (st_reg.split_seen && st_reg.blank_smp ##[1:200] FIRST_GROUP_O);
    c_split_fire: cover property (st_reg.firing);
    c_counter_clear: cover property (cnt_clear);
endmodule

/* verification/video_ram_model.sv */
// Video memory shift register and blanking source model for the clock generator bench
`timescale 1ns/1ps
module video_ram_model #(
    parameter int PIX_W = 32
) (
    input  wire logic             clk_i,          // Core clock
    input  wire logic             rst_n_i,        // Reset, active low
    input  wire logic             shift_clk_i,    // Shift clock from the device
    input  wire logic             video_clk_i,    // Video clock from the device
    input  wire logic             blank_req_i,    // Bench asks for blanking
    input  wire logic             split_req_i,    // Bench asks for a split flag
    output logic [PIX_W-1:0]      pixel_o,        // Pixel group on the bus
    output logic                  blank_n_o,      // Blanking pin, active low
    output logic                  split_flag_o    // split_flag_input pin
);
    logic             shift_q;
    logic             video_q;
    logic             split_seen;
    logic [PIX_W-1:0] group;

    // ----------------------------------------------------------------
    // Blanking follows the video clock, groups follow the shift clock
    // ----------------------------------------------------------------
    // reload in blanking
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_q      <= 1'b0;
            video_q      <= 1'b1;
            split_seen   <= 1'b0;
            group        <= '0;
            blank_n_o    <= 1'b1;
            split_flag_o <= 1'b0;
        end else begin
            shift_q      <= shift_clk_i;
            video_q      <= video_clk_i;
            split_flag_o <= split_req_i;
            if (video_clk_i && !video_q) begin
                blank_n_o <= !blank_req_i;
            end
            if (blank_n_o) begin
                split_seen <= 1'b0;
            end else if (split_flag_o) begin
                split_seen <= 1'b1;
            end
            if (!blank_n_o && !split_seen && !split_flag_o) begin
                group <= '0;                              // Shift register reloaded
            end else if (shift_clk_i && !shift_q) begin
                group <= group + 1'b1;                    // Next group shifted out
            end
        end
    end

    assign pixel_o = group;
endmodule

/* verification/shift_video_clock_generator_test.sv */
// Self-checking bench for the shift and video clock generator
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fail_count++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module shift_video_clock_generator_test;
    import clkgen_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [1:0]  addr = 2'h0;
    logic        rd = 1'b0;
    logic        wrt = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic        wait_req;
    logic        blank_n;
    logic        split_flag;
    logic [31:0] pixel;
    logic        sclk;
    logic        video_clock;
    logic        lclk;
    logic [31:0] pix_o;
    logic        blank_o;
    logic        first;
    logic        blank_req = 1'b0;
    logic        split_req = 1'b0;
    int          fail_count = 0;
    int          n_compared = 0;
    integer      seed = 32'h0241;

    shift_video_clock_generator dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wrt), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(wait_req), .BLANK_N_I(blank_n), .SPLIT_FLAG_I(split_flag),
        .PIXEL_I(pixel), .SHIFT_CLK_O(sclk), .VIDEO_CLK_O(video_clock), .LOAD_CLK_O(lclk),
        .PIXEL_O(pix_o), .BLANK_N_O(blank_o), .FIRST_GROUP_O(first));
    video_ram_model ram (.clk_i(clk), .rst_n_i(rst_n), .shift_clk_i(sclk), .video_clk_i(video_clock),
        .blank_req_i(blank_req), .split_req_i(split_req), .pixel_o(pixel),
        .blank_n_o(blank_n), .split_flag_o(split_flag));

    // Clock of 100 ns period
    always #50 clk = ~clk;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic int div_cyc(input int code);
        return 2 << code;
    endfunction

    task automatic conclude();
        if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int k;
        @(posedge clk);
        addr <= a; wdata <= d; rd <= !wr; wrt <= wr;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (wait_req === 1'b0) break;
        end
        q = rdata;
        rd <= 1'b0; wrt <= 1'b0;
        if (k == 50) begin fail_count++; conclude(); end
    endtask

    // Cycles between two rises of the shift or video clock
    task automatic meas(input bit vid, output int p);
        logic prev, cur;
        int   k, t0;
        prev = vid ? video_clock : sclk; t0 = -2; p = 0;
        for (k = 0; k < 300; k++) begin
            @(posedge clk);
            cur = vid ? video_clock : sclk;
            if (cur && !prev) begin
                if (t0 == -2) t0 = -1;        // First rise may follow a select change
                else if (t0 < 0) t0 = k;
                else begin p = k - t0; break; end
            end
            prev = cur;
        end
    endtask

    // One blanking period, optionally with a split flag inside it
    task automatic blank_seq(input logic [7:0] ocs, input logic en, input logic flag,
                             input int exp_bl, input int exp_first, input logic pix);
        logic [31:0] q;
        int          k, sr, lr, hi;
        logic        ps, pl;
        bus(1'b1, IDX_OCS, {24'h0, ocs}, q);
        bus(1'b1, IDX_CTRL, {31'h0, en}, q);
        blank_req <= 1'b1;
        repeat (40) @(posedge clk);
        sr = 0; lr = 0; hi = 0; ps = sclk; pl = lclk;
        for (k = 0; k < 80; k++) begin
            @(posedge clk);
            if (k == 10) split_req <= flag;
            if (k == 40) split_req <= 1'b0;
            sr += int'(sclk && !ps); lr += int'(lclk && !pl); hi += int'(sclk);
            ps = sclk; pl = lclk;
        end
        `CHK("blank shift rises", exp_bl, sr)
        `CHK("split pulse high", 1'b1, hi >= exp_bl)
        `CHK("latch clock runs", 1'b1, lr > 0)
        `CHK("aligned blank", 1'b0, blank_o)
        blank_req <= 1'b0;
        sr = 0; ps = sclk;
        for (k = 0; k < 400; k++) begin
            @(posedge clk);
            sr += int'(sclk && !ps); ps = sclk;
            if (first === 1'b1) break;
        end
        if (k == 400) begin fail_count++; conclude(); end
        `CHK("rises to first group", exp_first, sr)
        `CHK("blank released", 1'b1, blank_o)
        if (pix) begin
            repeat (4) @(posedge clk);
            `CHK("first group", 32'h1, pix_o)
        end
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] q;
        int          p, i, sc, vc, bad;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, IDX_OCS, 32'h0, q);
        `CHK("select reset", 32'h30, q)
        bus(1'b0, IDX_CTRL, 32'h0, q);
        `CHK("control reset", 32'h0, q)
        bus(1'b1, 2'h3, 32'hffffffff, q);
        bus(1'b0, 2'h3, 32'h0, q);
        `CHK("unmapped read", 32'h0, q)
        meas(1'b0, p);
        `CHK("shift reset period", 2, p)
        `CHK("video idle high", 1'b1, video_clock)
        bus(1'b1, IDX_OCS, 32'hff, q);
        bus(1'b0, IDX_OCS, 32'h0, q);
        `CHK("select mask", {24'h0, 8'hff & OCS_WMASK}, q)
        bad = 0;
        repeat (40) begin
            @(posedge clk);
            bad += int'(sclk !== 1'b0 || video_clock !== 1'b1);
        end
        `CHK("clocks off", 0, bad)
        bus(1'b0, IDX_STATUS, 32'h0, q);
        `CHK("status idle", (32'h1 << ST_VIDEO), q)
        bus(1'b1, IDX_OCS, 32'h09, q);
        @(posedge clk);                      // Restarted shift clock needs one edge
        bad = 0;
        repeat (32) begin
            @(posedge clk);
            bad += int'(sclk !== video_clock);
        end
        `CHK("clocks in phase", 0, bad)
        for (i = 0; i < 8; i++) begin
            sc = (i == 0) ? 5 : (i == 1) ? 0 : int'($unsigned($random(seed)) % 6);
            vc = (i == 0) ? 0 : (i == 1) ? 5 : int'($unsigned($random(seed)) % 6);
            bus(1'b1, IDX_OCS, {26'h0, 3'(vc), 3'(sc)}, q);
            meas(1'b0, p);
            `CHK("shift period", div_cyc(sc), p)
            meas(1'b1, p);
            `CHK("video period", div_cyc(vc), p)
        end
        blank_seq(8'h10, 1'b0, 1'b0, 0, 2, 1'b0);
        blank_seq(8'h0b, 1'b1, 1'b1, 1, 1, 1'b1);
        blank_seq(8'h0b, 1'b0, 1'b1, 0, 2, 1'b1);
        blank_seq(8'h1b, 1'b0, 1'b0, 0, 2, 1'b1);
        conclude();
    end
endmodule
